// file: rtl/tse_pkg.sv
// shared constants for the timer sync, event and status block
package tse_pkg;
  // register offsets are indices; byte address is four times the index
  localparam logic [7:0] IDX_MTC = 8'h01;
  localparam logic [7:0] IDX_SMC = 8'h02;
  localparam logic [7:0] IDX_IEN = 8'h03;
  localparam logic [7:0] IDX_EVF = 8'h04;
  localparam logic [7:0] IDX_OCF = 8'h05;
  localparam logic [7:0] IDX_SWE = 8'h06;
  localparam logic [7:0] IDX_CTL = 8'h07;
  localparam logic [7:0] IDX_CNT = 8'h08;
  localparam int ADDR_LSB = 2;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // field positions
  localparam int MMS_LO = 4;
  localparam int MSM_BIT = 7;
  localparam int TS_LO = 4;
  localparam int SMS_LO = 0;
  localparam int TRG_BIT = 6;
  localparam int UPD_BIT = 0;
  localparam int CH_LO = 1;
  localparam int CTL_CEN = 0;
  localparam int CTL_UPDATE_DISABLE = 1;
  localparam int CTL_URS = 2;
  localparam int CTL_DIR_LO = 4;
  // writable masks
  localparam logic [7:0] MTC_MASK = 8'h70;
  localparam logic [7:0] SMC_MASK = 8'hf7;
  localparam logic [7:0] FLAG_MASK = 8'h4f;
  localparam logic [7:0] OVC_MASK = 8'h0e;
  localparam logic [7:0] CTL_MASK = 8'h77;
  // master output codes
  localparam logic [2:0] MMS_RESET = 3'h0;
  localparam logic [2:0] MMS_ENABLE = 3'h1;
  localparam logic [2:0] MMS_UPDATE = 3'h2;
  // trigger source codes
  localparam logic [2:0] TS_INTERNAL_TRIGGER_ZERO = 3'h0;
  localparam logic [2:0] TS_INTERNAL_TRIGGER_THREE = 3'h3;
  localparam logic [2:0] TS_EDGE1 = 3'h4;
  localparam logic [2:0] TS_FILT1 = 3'h5;
  localparam logic [2:0] TS_FILT2 = 3'h6;
  localparam logic [2:0] TS_EXT = 3'h7;
  // slave behaviour codes
  localparam logic [2:0] SMS_OFF = 3'h0;
  localparam logic [2:0] SMS_RESET = 3'h4;
  localparam logic [2:0] SMS_GATED = 3'h5;
  localparam logic [2:0] SMS_TRIG = 3'h6;
  localparam logic [2:0] SMS_EXTCLK = 3'h7;
  localparam int CHANNELS = 3;
endpackage

// file: rtl/tse_timer_sync.sv
// timer synchronisation, interrupt flags and software event generation
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module tse_timer_sync #(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic internalTriggerZero,
  input wire logic internalTriggerThree,
  input wire logic chan1EdgeDetect,
  input wire logic filteredInputOne,
  input wire logic filteredInputTwo,
  input wire logic filteredExternalTrigger,
  input wire logic counterOverflow,
  input wire logic [CNT_W-1:0] counterValue,
  input wire logic [2:0] chanMatch,
  input wire logic [2:0] chanCapture,
  input wire logic [2:0] chanLowByteRead,
  output logic triggerOutput,
  output logic counterReinit,
  output logic prescalerClear,
  output logic updateEvent,
  output logic counterTick,
  output logic counterRunning,
  output logic [2:0] softCapture,
  output logic [CNT_W-1:0] softCaptureValue,
  output logic triggerIrq,
  output logic [2:0] chanIrq,
  output logic updateIrq
);
  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0] masterCtl_r;
  logic [7:0] slaveCtl_r;
  logic [7:0] irqEnable_r;
  logic trigFlag_r;
  logic updFlag_r;
  logic [2:0] chanFlags;
  logic [2:0] chanOver;
  logic [7:0] timerCtl_r;
  logic [7:0] swCmd_r;
  logic trigInDly_r;
  logic trigDelayed_r;
  logic trigFallDly_r;
  logic trigStarted_r;
  logic [CNT_W-1:0] capValue_r;
  logic [2:0] softCap_r;
  logic trigOutSrc;

  logic [7:0] regIdx;
  logic wrAcc;
  logic rdAcc;
  logic [7:0] wByte;
  logic [2:0] masterSel;
  logic [2:0] srcSel;
  logic [2:0] slaveSel;
  logic syncDelay;
  logic trigIn;
  logic trigRise;
  logic trigFall;
  logic trigRiseEff;
  logic gateEff;
  logic counterEnable;
  logic hwReset;
  logic updateEv;
  logic updFlagSet;
  logic trigFlagSet;
  logic [2:0] chanIsInput;
  logic [2:0] chanEvent;
  logic [2:0] chanFlagClr;

  localparam int ADDR_LSB_W = tse_pkg::ADDR_LSB + 8;
  localparam int ADDR_LSB = tse_pkg::ADDR_LSB;
  assign regIdx = paddr[ADDR_LSB_W-1:ADDR_LSB];
  assign wrAcc = psel && penable && pwrite;
  assign rdAcc = psel && penable && !pwrite;
  assign wByte = pwdata[7:0];
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign masterSel = masterCtl_r[tse_pkg::MMS_LO +: 3];
  assign srcSel = slaveCtl_r[tse_pkg::TS_LO +: 3];
  assign slaveSel = slaveCtl_r[tse_pkg::SMS_LO +: 3];
  assign syncDelay = slaveCtl_r[tse_pkg::MSM_BIT];
  assign chanIsInput = timerCtl_r[tse_pkg::CTL_DIR_LO +: 3];

  // ----------------------------------------------------------------
  // trigger input selection and edge detection
  // ----------------------------------------------------------------
  always_comb begin
    trigIn = 1'b0;
    unique case (srcSel)
      tse_pkg::TS_INTERNAL_TRIGGER_ZERO: trigIn = internalTriggerZero;
      tse_pkg::TS_INTERNAL_TRIGGER_THREE: trigIn = internalTriggerThree;
      tse_pkg::TS_EDGE1: trigIn = chan1EdgeDetect;
      tse_pkg::TS_FILT1: trigIn = filteredInputOne;
      tse_pkg::TS_FILT2: trigIn = filteredInputTwo;
      tse_pkg::TS_EXT: trigIn = filteredExternalTrigger;
      default: trigIn = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trigInDly_r <= 1'b0;
    end else begin
      trigInDly_r <= trigIn;
    end
  end

  // the edge detector trusts software to hold the source steady
  assign trigRise = trigIn && !trigInDly_r;
  assign trigFall = !trigIn && trigInDly_r;

  // delay the trigger effect one cycle so linked timers see trigger output first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trigDelayed_r <= 1'b0;
      trigFallDly_r <= 1'b0;
    end else begin
      trigDelayed_r <= trigRise;
      trigFallDly_r <= trigFall;
    end
  end

  assign trigRiseEff = syncDelay ? trigDelayed_r : trigRise;
  assign gateEff = syncDelay ? trigInDly_r : trigIn;

  // ----------------------------------------------------------------
  // slave behaviour
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trigStarted_r <= 1'b0;
    end else if (slaveSel != tse_pkg::SMS_TRIG) begin
      trigStarted_r <= 1'b0;
    end else if (trigRiseEff) begin
      trigStarted_r <= 1'b1;
    end
  end

  always_comb begin
    counterEnable = timerCtl_r[tse_pkg::CTL_CEN];
    counterTick = 1'b0;
    hwReset = 1'b0;
    unique case (slaveSel)
      tse_pkg::SMS_RESET: begin
        hwReset = trigRiseEff;
      end
      tse_pkg::SMS_GATED: begin
        counterEnable = timerCtl_r[tse_pkg::CTL_CEN] | gateEff;
      end
      tse_pkg::SMS_TRIG: begin
        counterEnable = timerCtl_r[tse_pkg::CTL_CEN] | trigStarted_r;
      end
      default: begin
      end
    endcase
    if (slaveSel == tse_pkg::SMS_EXTCLK) begin
      counterTick = counterEnable && trigRiseEff;
    end else if (slaveSel == tse_pkg::SMS_GATED) begin
      counterTick = gateEff;
    end else begin
      counterTick = counterEnable;
    end
  end

  assign counterReinit = swCmd_r[tse_pkg::UPD_BIT] || hwReset;
  assign prescalerClear = counterReinit;
  assign updateEv = !timerCtl_r[tse_pkg::CTL_UPDATE_DISABLE] &&
    (counterOverflow || swCmd_r[tse_pkg::UPD_BIT] || hwReset);
  assign updateEvent = updateEv;
  assign counterRunning = counterEnable;

  // ----------------------------------------------------------------
  // trigger output
  // ----------------------------------------------------------------
  always_comb begin
    trigOutSrc = 1'b0;
    unique case (masterSel)
      tse_pkg::MMS_RESET: trigOutSrc = swCmd_r[tse_pkg::UPD_BIT] || hwReset;
      tse_pkg::MMS_ENABLE: trigOutSrc = counterEnable;
      tse_pkg::MMS_UPDATE: trigOutSrc = updateEv;
      default: trigOutSrc = 1'b0;
    endcase
  end

  // registered output: every selected source lags the internal event by one edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      triggerOutput <= 1'b0;
    end else begin
      triggerOutput <= trigOutSrc;
    end
  end

  // ----------------------------------------------------------------
  // command register: self-clearing one cycle after the write
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      swCmd_r <= tse_pkg::RESET_BYTE;
    end else if (wrAcc && regIdx == tse_pkg::IDX_SWE) begin
      swCmd_r <= wByte & tse_pkg::FLAG_MASK;
    end else begin
      swCmd_r <= tse_pkg::RESET_BYTE;
    end
  end

  // ----------------------------------------------------------------
  // status flags; a hardware set wins over a software clear
  // ----------------------------------------------------------------
  assign trigFlagSet = swCmd_r[tse_pkg::TRG_BIT] ||
    (slaveSel != tse_pkg::SMS_OFF &&
     (trigRiseEff || (slaveSel == tse_pkg::SMS_GATED && (syncDelay ?
       trigFallDly_r : trigFall))));
  assign updFlagSet = !timerCtl_r[tse_pkg::CTL_UPDATE_DISABLE] && (counterOverflow ||
    (!timerCtl_r[tse_pkg::CTL_URS] && (swCmd_r[tse_pkg::UPD_BIT] || hwReset)));

  for (genvar ch = 0; ch < tse_pkg::CHANNELS; ch++) begin : gChan
    localparam int FB = tse_pkg::CH_LO + ch;
    logic flag_r;
    logic overCap_r;
    assign chanEvent[ch] = swCmd_r[FB] ||
      (chanIsInput[ch] ? chanCapture[ch] : chanMatch[ch]);
    assign chanFlagClr[ch] = (wrAcc && regIdx == tse_pkg::IDX_EVF && !wByte[FB]) ||
      (chanIsInput[ch] && chanLowByteRead[ch]);

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        flag_r <= 1'b0;
      end else if (chanEvent[ch]) begin
        flag_r <= 1'b1;
      end else if (chanFlagClr[ch]) begin
        flag_r <= 1'b0;
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        overCap_r <= 1'b0;
      end else if (chanIsInput[ch] && chanEvent[ch] && flag_r) begin
        overCap_r <= 1'b1;
      end else if (wrAcc && regIdx == tse_pkg::IDX_OCF && !wByte[FB]) begin
        overCap_r <= 1'b0;
      end
    end

    assign chanFlags[ch] = flag_r;
    assign chanOver[ch] = overCap_r;
    assign chanIrq[ch] = flag_r && irqEnable_r[FB];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trigFlag_r <= 1'b0;
    end else if (trigFlagSet) begin
      trigFlag_r <= 1'b1;
    end else if (wrAcc && regIdx == tse_pkg::IDX_EVF && !wByte[tse_pkg::TRG_BIT]) begin
      trigFlag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      updFlag_r <= 1'b0;
    end else if (updFlagSet) begin
      updFlag_r <= 1'b1;
    end else if (wrAcc && regIdx == tse_pkg::IDX_EVF && !wByte[tse_pkg::UPD_BIT]) begin
      updFlag_r <= 1'b0;
    end
  end

  assign triggerIrq = trigFlag_r && irqEnable_r[tse_pkg::TRG_BIT];
  assign updateIrq = updFlag_r && irqEnable_r[tse_pkg::UPD_BIT];

  // ----------------------------------------------------------------
  // software capture of the running counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capValue_r <= '0;
      softCap_r <= 3'h0;
    end else begin
      softCap_r <= swCmd_r[tse_pkg::CH_LO +: 3] & chanIsInput;
      if (|(swCmd_r[tse_pkg::CH_LO +: 3] & chanIsInput)) begin
        capValue_r <= counterValue;
      end
    end
  end

  assign softCapture = softCap_r;
  assign softCaptureValue = capValue_r;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      masterCtl_r <= tse_pkg::RESET_BYTE;
      slaveCtl_r <= tse_pkg::RESET_BYTE;
      irqEnable_r <= tse_pkg::RESET_BYTE;
      timerCtl_r <= tse_pkg::RESET_BYTE;
    end else if (wrAcc) begin
      unique case (regIdx)
        tse_pkg::IDX_MTC: masterCtl_r <= wByte & tse_pkg::MTC_MASK;
        tse_pkg::IDX_SMC: slaveCtl_r <= wByte & tse_pkg::SMC_MASK;
        tse_pkg::IDX_IEN: irqEnable_r <= wByte & tse_pkg::FLAG_MASK;
        tse_pkg::IDX_CTL: timerCtl_r <= wByte & tse_pkg::CTL_MASK;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    unique case (regIdx)
      tse_pkg::IDX_MTC: prdata = {24'h000000, masterCtl_r};
      tse_pkg::IDX_SMC: prdata = {24'h000000, slaveCtl_r};
      tse_pkg::IDX_IEN: prdata = {24'h000000, irqEnable_r};
      tse_pkg::IDX_EVF: prdata = {24'h000000, 1'b0, trigFlag_r, 2'h0, chanFlags, updFlag_r};
      tse_pkg::IDX_OCF: prdata = {24'h000000, 4'h0, chanOver, 1'b0};
      tse_pkg::IDX_CTL: prdata = {24'h000000, timerCtl_r};
      tse_pkg::IDX_CNT: prdata = 32'(capValue_r);
      default: prdata = 32'h00000000;
    endcase
    if (!rdAcc) begin
      prdata = 32'h00000000;
    end
  end
endmodule

// file: verif/tse_checker.sv
// concurrent checks on the timer sync, event and status ports
`timescale 1ns/1ps
module tse_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic triggerOutput,
  input wire logic counterReinit,
  input wire logic prescalerClear,
  input wire logic updateEvent,
  input wire logic counterTick,
  input wire logic counterRunning,
  input wire logic triggerIrq,
  input wire logic [2:0] chanIrq,
  input wire logic updateIrq
);
  // ----------------------------------------
  // shadow of the software-written controls
  // ----------------------------------------
  logic wr;
  logic swe;
  logic [7:0] idx;
  logic [7:0] mtc_r, smc_r, ien_r, ctl_r;
  logic [2:0] master_output_select, slave_behaviour_select;
  assign idx = paddr[9:2];
  assign wr = psel && penable && pwrite;
  assign swe = wr && idx == tse_pkg::IDX_SWE;
  assign master_output_select = mtc_r[6:4];
  assign slave_behaviour_select = smc_r[2:0];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mtc_r <= 8'h00;
      smc_r <= 8'h00;
      ien_r <= 8'h00;
      ctl_r <= 8'h00;
    end else if (wr) begin
      if (idx == tse_pkg::IDX_MTC) mtc_r <= pwdata[7:0] & tse_pkg::MTC_MASK;
      if (idx == tse_pkg::IDX_SMC) smc_r <= pwdata[7:0] & tse_pkg::SMC_MASK;
      if (idx == tse_pkg::IDX_IEN) ien_r <= pwdata[7:0] & tse_pkg::FLAG_MASK;
      if (idx == tse_pkg::IDX_CTL) ctl_r <= pwdata[7:0] & tse_pkg::CTL_MASK;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  trg_reset_a: assert property (
    $past(master_output_select) == 3'h0 && $past(slave_behaviour_select) != 3'h4 |-> triggerOutput == $past(counterReinit))
    else $error("trigger output does not follow the update command");
  trg_enable_a: assert property (
    $past(master_output_select) == 3'h1 |-> triggerOutput == $past(counterRunning))
    else $error("trigger output does not follow counter enable");
  trg_update_a: assert property (
    $past(master_output_select) == 3'h2 |-> triggerOutput == $past(updateEvent))
    else $error("trigger output does not follow update event");
  irq_gate_a: assert property (
    ({triggerIrq, chanIrq, updateIrq} & ~{ien_r[6], ien_r[3:0]}) == 5'h00)
    else $error("interrupt raised while disabled");
  prdata_idle_a: assert property (
    !(psel && penable && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside a read access");
  ien_read_a: assert property (
    psel && penable && !pwrite && idx == tse_pkg::IDX_IEN |-> prdata == {24'h0, ien_r})
    else $error("enable register reads wrong");
  idle_tick_a: assert property (
    slave_behaviour_select == 3'h0 |-> counterTick == ctl_r[0] && counterRunning == ctl_r[0])
    else $error("count enable wrong with controller off");
  extclk_a: assert property (
    slave_behaviour_select == 3'h7 && $past(slave_behaviour_select) == 3'h7 && counterTick |=> !counterTick || slave_behaviour_select != 3'h7)
    else $error("external clock ticked twice in a row");
  trig_cmd_a: assert property (
    swe && pwdata[6] |-> ##2 (triggerIrq || !ien_r[6]))
    else $error("trigger command raised no interrupt");
  ug_reinit_a: assert property (
    swe && pwdata[0] |=> counterReinit && prescalerClear)
    else $error("update command did not reinitialise");
endmodule

// file: verif/tse_far_model.sv
// far side: trigger sources, channel events and the counter core
`timescale 1ns/1ps
module tse_far_model #(
  parameter logic [15:0] TOP = 16'h000f
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic counterTick,
  input wire logic counterReinit,
  output logic internalTriggerZero,
  output logic internalTriggerThree,
  output logic chan1EdgeDetect,
  output logic filteredInputOne,
  output logic filteredInputTwo,
  output logic filteredExternalTrigger,
  output logic counterOverflow,
  output logic [15:0] counterValue,
  output logic [2:0] chanMatch,
  output logic [2:0] chanCapture,
  output logic [2:0] chanLowByteRead
);
  logic [5:0] src;
  logic [2:0][2:0] ev;
  logic [15:0] cnt_r;
  initial begin
    src = 6'h00;
    ev = '0;
  end
  assign {filteredExternalTrigger, filteredInputTwo, filteredInputOne} = src[5:3];
  assign {chan1EdgeDetect, internalTriggerThree, internalTriggerZero} = src[2:0];
  assign chanMatch = ev[0];
  assign chanCapture = ev[1];
  assign chanLowByteRead = ev[2];
  assign counterValue = cnt_r;
  // small top keeps overflow waits short
  assign counterOverflow = counterTick && !counterReinit && cnt_r == TOP;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_r <= 16'h0000;
    else if (counterReinit) cnt_r <= 16'h0000;
    else if (counterTick) cnt_r <= (cnt_r == TOP) ? 16'h0000 : cnt_r + 16'h0001;
  end
  task automatic drive(input int i, input logic lv);
    @(posedge clk);
    src[i] <= lv;
  endtask
  task automatic pulse(input int k, input int ch);
    @(posedge clk);
    ev[k][ch] <= 1'b1;
    @(posedge clk);
    ev[k][ch] <= 1'b0;
  endtask
endmodule

// file: verif/tse_timer_sync_tb.sv
// self-checking bench for the timer sync, event and status block
`timescale 1ns/1ps
module tse_timer_sync_tb;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic internalTriggerZero, internalTriggerThree, chan1EdgeDetect;
  logic filteredInputOne, filteredInputTwo, filteredExternalTrigger;
  logic counterOverflow, triggerOutput, counterReinit, prescalerClear;
  logic updateEvent, counterTick, counterRunning, triggerIrq, updateIrq;
  logic [15:0] counterValue, softCaptureValue;
  logic [2:0] chanMatch, chanCapture, chanLowByteRead, softCapture, chanIrq;
  logic [7:0] rd, v;
  logic [2:0] tsc [6] = '{3'h0, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
  int n_mismatch, n_tests, lat0, lat1;
  tse_timer_sync u_tse_timer_sync (.*);
  tse_far_model u_tse_far_model (.*);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h0, got}, {7'h0, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h0, idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk8(rd, exp);
  endtask
  task automatic wait_ovf();
    for (int k = 0; k < 64; k++) begin
      @(posedge clk);
      if (counterOverflow === 1'b1) break;
    end
    cyc(2);
  endtask
  // sync delay is measured, not assumed, so both settings are compared
  task automatic measure(output int n);
    n = 0;
    u_tse_far_model.drive(0, 1'b1);
    while (counterRunning !== 1'b1 && n < 10) begin
      @(posedge clk);
      n++;
    end
    chk1(counterTick, 1'b1);
    apb(1'b1, 8'h04, 8'h00);
    u_tse_far_model.drive(0, 1'b0);
    cyc(4);
    chk1(counterRunning, 1'b0);
    rdchk(8'h04, 8'h40);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #200us;
    n_mismatch++;
    give_verdict();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    n_mismatch = 0;
    n_tests = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    cyc(2);
    rst_n <= 1'b1;
    for (int i = 1; i <= 6; i++) rdchk(8'(i), 8'h00);
    apb(1'b1, 8'h03, 8'hff);
    rdchk(8'h03, 8'h4f);
    apb(1'b1, 8'h01, 8'hff);
    rdchk(8'h01, 8'h70);
    apb(1'b1, 8'h02, 8'hff);
    rdchk(8'h02, 8'hf7);
    apb(1'b1, 8'h02, 8'h70);
    apb(1'b1, 8'h02, 8'h00);
    apb(1'b1, 8'h01, 8'h00);
    apb(1'b1, 8'h09, 8'h5a);
    rdchk(8'h09, 8'h00);
    $display("test registers done");
    apb(1'b1, 8'h03, 8'h40);
    apb(1'b1, 8'h02, 8'h05);
    apb(1'b1, 8'h06, 8'h40);
    cyc(2);
    chk1(triggerIrq, 1'b1);
    rdchk(8'h04, 8'h40);
    apb(1'b1, 8'h03, 8'h00);
    cyc(1);
    chk1(triggerIrq, 1'b0);
    apb(1'b1, 8'h04, 8'hbf);
    rdchk(8'h04, 8'h00);
    apb(1'b1, 8'h02, 8'h00);
    $display("test trigger command done");
    apb(1'b1, 8'h01, 8'h20);
    apb(1'b1, 8'h06, 8'h01);
    rdchk(8'h04, 8'h01);
    apb(1'b1, 8'h04, 8'h00);
    apb(1'b1, 8'h07, 8'h04);
    apb(1'b1, 8'h06, 8'h01);
    rdchk(8'h04, 8'h00);
    apb(1'b1, 8'h07, 8'h05);
    wait_ovf();
    apb(1'b1, 8'h07, 8'h04);
    rdchk(8'h04, 8'h01);
    apb(1'b1, 8'h03, 8'h01);
    cyc(1);
    chk1(updateIrq, 1'b1);
    apb(1'b1, 8'h04, 8'h00);
    apb(1'b1, 8'h07, 8'h03);
    wait_ovf();
    apb(1'b1, 8'h07, 8'h02);
    rdchk(8'h04, 8'h00);
    $display("test update done");
    apb(1'b1, 8'h07, 8'h13);
    apb(1'b1, 8'h07, 8'h12);
    cyc(1);
    v = counterValue[7:0];
    apb(1'b1, 8'h06, 8'h02);
    cyc(2);
    chk8({5'h0, softCapture}, 8'h01);
    rdchk(8'h08, v);
    chk8(softCaptureValue[7:0], v);
    apb(1'b1, 8'h06, 8'h02);
    rdchk(8'h05, 8'h02);
    rdchk(8'h04, 8'h02);
    u_tse_far_model.pulse(2, 0);
    rdchk(8'h04, 8'h00);
    apb(1'b1, 8'h05, 8'h00);
    rdchk(8'h05, 8'h00);
    u_tse_far_model.pulse(0, 1);
    rdchk(8'h04, 8'h04);
    apb(1'b1, 8'h07, 8'h42);
    u_tse_far_model.pulse(1, 2);
    u_tse_far_model.pulse(1, 2);
    rdchk(8'h04, 8'h0c);
    rdchk(8'h05, 8'h08);
    apb(1'b1, 8'h03, 8'h0e);
    cyc(1);
    chk8({5'h0, chanIrq}, 8'h06);
    $display("test channels done");
    apb(1'b1, 8'h07, 8'h04);
    for (int s = 0; s < 6; s++) begin
      apb(1'b1, 8'h02, {1'b0, tsc[s], 4'h0});
      apb(1'b1, 8'h02, {1'b0, tsc[s], 4'h4});
      apb(1'b1, 8'h04, 8'h00);
      u_tse_far_model.drive(s, 1'b1);
      cyc(4);
      chk8(counterValue[7:0], 8'h00);
      rdchk(8'h04, 8'h40);
      u_tse_far_model.drive(s, 1'b0);
      apb(1'b1, 8'h02, {1'b0, tsc[s], 4'h0});
    end
    $display("test trigger sources done");
    apb(1'b1, 8'h01, 8'h10);
    apb(1'b1, 8'h02, 8'h05);
    measure(lat0);
    apb(1'b1, 8'h02, 8'h85);
    measure(lat1);
    chk8(8'(lat1), 8'(lat0 + 1));
    apb(1'b1, 8'h02, 8'h06);
    u_tse_far_model.drive(0, 1'b1);
    u_tse_far_model.drive(0, 1'b0);
    cyc(4);
    chk1(counterRunning, 1'b1);
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    apb(1'b1, 8'h07, 8'h01);
    cyc(1);
    chk1(counterTick, 1'b1);
    apb(1'b1, 8'h02, 8'h07);
    cyc(1);
    v = counterValue[7:0];
    for (int k = 0; k < 3; k++) begin
      u_tse_far_model.drive(0, 1'b1);
      u_tse_far_model.drive(0, 1'b0);
    end
    cyc(3);
    chk8(counterValue[7:0], v + 8'h03);
    $display("test slave modes done");
    give_verdict();
  end
endmodule
bind tse_timer_sync tse_checker u_tse_checker (.*);
